// *** bench/tb_top.sv ***
`include "tpgio_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_D = {2'b00, `TPGIO_IDX_A_DATA, 2'b00};
    localparam logic [11:0] B_D = {2'b00, `TPGIO_IDX_B_DATA, 2'b00};
    localparam logic [11:0] C_D = {2'b00, `TPGIO_IDX_C_DATA, 2'b00};
    localparam logic [11:0] A_R = {2'b00, `TPGIO_IDX_A_DIR, 2'b00};
    localparam logic [11:0] B_R = {2'b00, `TPGIO_IDX_B_DIR, 2'b00};
    localparam logic [11:0] C_R = {2'b00, `TPGIO_IDX_C_DIR, 2'b00};
    localparam logic [11:0] A_P = {2'b00, `TPGIO_IDX_A_PUE, 2'b00};
    localparam logic [11:0] C_P = {2'b00, `TPGIO_IDX_C_PUE, 2'b00};
    localparam logic [11:0] KB = {2'b00, `TPGIO_IDX_KBI_EN, 2'b00};
    localparam logic [11:0] AN = {2'b00, `TPGIO_IDX_ADC_SEL, 2'b00};
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pu, pb_in, pb_out, pb_oe, an_pins, kp;
    logic [6:0] pc_in, pc_out, pc_oe, pc_pu;
    logic [7:0] a_en = 8'h00, a_val = 8'h00, b_en = 8'h00, b_val = 8'h00;
    logic [6:0] c_en = 7'h00, c_val = 7'h00;
    int failures = 0;
    int total_checks = 0;

    always #2 ref_clk = ~ref_clk;

    tpgio_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
        .port_a_pullup(pa_pu), .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe),
        .analog_channel_pins(an_pins), .port_c_in(pc_in), .port_c_out(pc_out),
        .port_c_oe(pc_oe), .port_c_pullup(pc_pu), .keypad_input_pins(kp));
    tpgio_board #(.W(8)) u_pa (.clk(ref_clk), .oe(pa_oe), .drv(pa_out), .pu(pa_pu),
        .ext_en(a_en), .ext_val(a_val), .level(pa_in));
    // the analog port has no pullups
    tpgio_board #(.W(8)) u_pb (.clk(ref_clk), .oe(pb_oe), .drv(pb_out), .pu(8'h00),
        .ext_en(b_en), .ext_val(b_val), .level(pb_in));
    tpgio_board #(.W(7)) u_pc (.clk(ref_clk), .oe(pc_oe), .drv(pc_out), .pu(pc_pu),
        .ext_en(c_en), .ext_val(c_val), .level(pc_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer; waits on pready as long as it takes, the watchdog bounds it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // covers pin sync and registered outputs
    task automatic settle;
        repeat (5) @(posedge ref_clk);
    endtask

    task automatic t_dir;
        chk({pa_oe, pb_oe, pc_oe}, 23'h000000);
        rdc(A_R, 32'h0000_0000);
        apb(1'b1, A_R, 32'hFFFF_FF5A);
        apb(1'b1, B_R, 32'h0000_00A5);
        apb(1'b1, C_R, 32'h0000_009F);
        settle;
        rdc(A_R, 32'h0000_005A);
        rdc(B_R, 32'h0000_00A5);
        rdc(C_R, 32'h0000_001F);
        chk({pa_oe, pb_oe, pc_oe}, {8'h5A, 8'hA5, 7'h1F});
        apb(1'b1, B_R, 32'h0000_0000);
        apb(1'b1, C_R, 32'h0000_0000);
        apb(1'b1, A_R, 32'h0000_0000);
    endtask

    task automatic t_latch;
        a_en <= 8'hFF;
        a_val <= 8'h3C;
        apb(1'b1, A_D, 32'h0000_00C3);
        settle;
        rdc(A_D, 32'h0000_003C);
        chk(pa_out, 8'hC3);
        a_en <= 8'hF0;
        apb(1'b1, A_D, 32'h0000_00C3);
        apb(1'b1, A_R, 32'h0000_000F);
        apb(1'b1, KB, 32'h0000_0081);
        settle;
        rdc(A_D, 32'h0000_0033);
        chk(kp, 8'h01);
    endtask

    task automatic t_pull;
        a_en <= 8'h00;
        apb(1'b1, A_P, 32'h0000_00FF);
        settle;
        chk(pa_pu, 8'hF0);
        rdc(A_D, 32'h0000_00F3);
        apb(1'b1, A_R, 32'h0000_0000);
        settle;
        chk(pa_pu, 8'hFF);
        apb(1'b1, C_P, 32'h0000_00FF);
        settle;
        chk(pc_pu, 7'h7F);
        rdc(C_P, 32'h0000_007F);
        rdc(C_D, 32'h0000_007F);
        c_en <= 7'h0F;
        c_val <= 7'h05;
        apb(1'b1, C_D, 32'h0000_00AA);
        settle;
        chk(pc_out, 7'h2A);
        rdc(C_D, 32'h0000_0075);
    endtask

    task automatic t_analog;
        apb(1'b1, B_D, 32'h0000_0096);
        apb(1'b1, B_R, 32'h0000_00FF);
        apb(1'b1, AN, 32'h0000_000D);
        settle;
        chk({an_pins, pb_oe}, {8'h20, 8'hDF});
        rdc(B_D, 32'h0000_0096);
        apb(1'b1, AN, 32'h0000_0000);
        settle;
        chk({an_pins, pb_oe}, {8'h00, 8'hFF});
        b_en <= 8'hF0;
        b_val <= 8'hA0;
        apb(1'b1, B_R, 32'h0000_000F);
        settle;
        rdc(B_D, 32'h0000_00A6);
    endtask

    // a reset in mid-run clears directions but keeps the latches
    task automatic t_rst2;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk(pb_out, 8'h96);
        chk(pb_oe, 8'h00);
        rdc(B_R, 32'h0000_0000);
    endtask

    task automatic t_bad;
        apb(1'b1, 12'h0FC, 32'h0000_00FF);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b0, 12'h400, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_dir;
        t_latch;
        t_pull;
        t_analog;
        t_rst2;
        t_bad;
        conclude;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude;
    end
endmodule

// *** bench/tpgio_asserts.sv ***
// protocol and pin-control relations seen at the top-level ports
module tpgio_asserts (
    input logic        ref_clk,
    input logic        sys_rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [7:0]  port_a_oe,
    input logic [7:0]  port_a_pullup,
    input logic [7:0]  port_b_oe,
    input logic [7:0]  analog_channel_pins,
    input logic [6:0]  port_c_oe,
    input logic [6:0]  port_c_pullup
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // leaving reset every pin must be an input
    a_reset_inputs: assert property ($fell(sys_rst) |->
        (port_a_oe == 8'h00 && port_b_oe == 8'h00 && port_c_oe == 7'h00))
        else $error("driver enabled right after reset");
    a_pullup_a_out: assert property ((port_a_oe & port_a_pullup) == 8'h00)
        else $error("first port pullup on an output bit");
    a_pullup_c_out: assert property ((port_c_oe & port_c_pullup) == 7'h00)
        else $error("third port pullup on an output bit");
    a_analog_no_drive: assert property ((port_b_oe & analog_channel_pins) == 8'h00)
        else $error("analog pin still driven");
    a_analog_onehot: assert property ($onehot0(analog_channel_pins))
        else $error("more than one analog pin selected");
    // zero wait states and a single-cycle answer keep the bus moving
    a_ready_setup: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("answer not one cycle after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("answer outside an access phase");
    a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data not zero on a write");
    a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error without answer or with data");
endmodule

bind tpgio_top tpgio_asserts u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_oe(port_a_oe), .port_a_pullup(port_a_pullup), .port_b_oe(port_b_oe),
    .analog_channel_pins(analog_channel_pins), .port_c_oe(port_c_oe),
    .port_c_pullup(port_c_pullup)
);

// *** bench/tpgio_board.sv ***
// board side of one port: resolves each pin level fed back to the device
module tpgio_board #(parameter int W = 8) (
    input  logic         clk,
    input  logic [W-1:0] oe,
    input  logic [W-1:0] drv,
    input  logic [W-1:0] pu,
    input  logic [W-1:0] ext_en,
    input  logic [W-1:0] ext_val,
    output logic [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt_q = 1'b0;

    // a floating pin wanders every cycle so a stale level never reads back
    always @(posedge clk) flt_q <= ~flt_q;

    // device driver wins, then the board, then the pullup
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) level[i] = drv[i];
            else if (ext_en[i]) level[i] = ext_val[i];
            else if (pu[i]) level[i] = 1'b1;
            else level[i] = flt_q;
        end
    end
endmodule

// *** src/tpgio_defines.vh ***
`ifndef TPGIO_DEFINES_VH
`define TPGIO_DEFINES_VH

// register indices as printed; byte address is four times the index
`define TPGIO_IDX_A_DATA     8'h00
`define TPGIO_IDX_B_DATA     8'h01
`define TPGIO_IDX_C_DATA     8'h02
`define TPGIO_IDX_A_DIR      8'h04
`define TPGIO_IDX_B_DIR      8'h05
`define TPGIO_IDX_C_DIR      8'h06
`define TPGIO_IDX_A_PUE      8'h0D
`define TPGIO_IDX_C_PUE      8'h0E
`define TPGIO_IDX_KBI_EN     8'h10
`define TPGIO_IDX_ADC_SEL    8'h11

// field layout
`define TPGIO_C_MASK         8'h7F
`define TPGIO_ADC_EN_BIT     3
`define TPGIO_ADC_CH_MSB     2

// reset values
`define TPGIO_DIR_RST        8'h00
`define TPGIO_PUE_RST        8'h00
`define TPGIO_KBI_RST        8'h00
`define TPGIO_ADC_RST        4'h0

`endif

// *** src/tpgio_pin.v ***
`include "tpgio_defines.vh"

// per-port pin logic: output drive, pullup gating, read-back selection
module tpgio_pin (
    input  wire [7:0] latch_val,
    input  wire [7:0] dir_val,
    input  wire [7:0] pue_val,
    input  wire [7:0] pin_level,
    input  wire [7:0] analog_force,
    output wire [7:0] drive_en,
    output wire [7:0] pullup_en,
    output wire [7:0] read_val
);
    // analog selection overrides direction and takes the pin off digital use
    assign drive_en  = dir_val & ~analog_force;                // [R1] [R13]
    // pullup only on inputs; reconnects as soon as direction returns to input
    assign pullup_en = pue_val & ~dir_val & ~analog_force;     // [R9] [R10]
    // output bits read the latch, input bits read the pin
    assign read_val  = (dir_val & latch_val) | (~dir_val & pin_level); // [R5] [R6] [R8]
endmodule

// *** src/tpgio_sync.v ***
// two-stage synchroniser for an 8-bit group of pin levels
module tpgio_sync (
    input  wire       ref_clk,
    input  wire       sys_rst,
    input  wire [7:0] async_in,
    output reg  [7:0] sync_out
);
    reg [7:0] meta_q;

    // first stage feeds only the second stage
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q   <= 8'h00;
            sync_out <= 8'h00;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** src/tpgio_top.v ***
// Overview of operation
// (R1) direction bit 1 enables the pin driver; 0 makes the pin an input.
// (R2) reset clears all direction registers, so every pin starts as input.
// (R3) direction registers are readable and return the last value written.
// (R4) port data latches are not touched by reset.
// (R5) output-direction bits read back the stored latch value.
// (R6) input-direction bits read back the live pin level.
// (R7) writes to a data register always update the latch.
// (R8) writing an input bit changes only the latch, not the read-back.
// (R9) first and third ports: pullup on input bits whose enable is 1.
// (R10) pullup is dropped while a bit is output, restored on return to input.
// (R11) first port has eight independent software pullup enables.
// (R12) second port is eight bits, shared with analog, with no pullups.
// (R13) analog channel selection overrides direction and forces analog input.
// (R14) unselected second-port pins act as ordinary digital I/O.
// (R15) third port implements bits 0 to 6 only.
// (R16) software writes the latch before turning a bit to output.
// (R17) reduced package: software keeps third-port bits 5 and 6 as inputs.
// (R18) first-port pins serve as keypad interrupt inputs when enabled.
// (R19) third-port bit 7 reads zero and ignores writes.
//
// Design decision made here: the APB interface to the registers.
`include "tpgio_defines.vh"

module tpgio_top (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  port_a_in,
    output reg  [7:0]  port_a_out,
    output reg  [7:0]  port_a_oe,
    output reg  [7:0]  port_a_pullup,
    input  wire [7:0]  port_b_in,
    output reg  [7:0]  port_b_out,
    output reg  [7:0]  port_b_oe,
    output reg  [7:0]  analog_channel_pins,
    input  wire [6:0]  port_c_in,
    output reg  [6:0]  port_c_out,
    output reg  [6:0]  port_c_oe,
    output reg  [6:0]  port_c_pullup,
    output reg  [7:0]  keypad_input_pins
);
    // latches carry no reset so their content survives a reset
    reg  [7:0]  first_port_latch;
    reg  [7:0]  second_port_latch;
    reg  [7:0]  third_port_latch;
    reg  [7:0]  first_port_direction_q;
    reg  [7:0]  second_port_direction_q;
    reg  [7:0]  third_port_direction_q;
    reg  [7:0]  first_port_pullup_enable_q;
    reg  [7:0]  third_port_pullup_enable_q;
    reg  [7:0]  keypad_irq_enable_bits_q;
    reg  [3:0]  adc_select_q;
    reg  [31:0] prdata_d;
    reg         pslverr_d;
    reg  [7:0]  analog_force;

    wire [7:0]  a_sync;
    wire [7:0]  b_sync;
    wire [7:0]  c_sync;
    wire [7:0]  a_drv;
    wire [7:0]  a_pu;
    wire [7:0]  a_rd;
    wire [7:0]  b_drv;
    wire [7:0]  b_pu;
    wire [7:0]  b_rd;
    wire [7:0]  c_drv;
    wire [7:0]  c_pu;
    wire [7:0]  c_rd;
    wire [8:0]  widx;
    wire [7:0]  idx;
    wire        addr_ok;
    wire        wr_acc;
    wire        rd_acc;
    wire        wr_go;
    // one write strobe per register
    wire        wr_a_data;
    wire        wr_b_data;
    wire        wr_c_data;
    wire        wr_a_dir;
    wire        wr_b_dir;
    wire        wr_c_dir;
    wire        wr_a_pue;
    wire        wr_c_pue;
    wire        wr_kbi;
    wire        wr_adc;

    // decode a word index from a byte address; non-aligned or high is unmapped
    function [8:0] word_index;
        input [11:0] addr;
        begin
            word_index = {(addr[1:0] == 2'b00 && addr[11:10] == 2'b00), addr[9:2]};
        end
    endfunction

    // true when the index names an implemented register
    function mapped;
        input [7:0] i;
        begin
            case (i)
                `TPGIO_IDX_A_DATA, `TPGIO_IDX_B_DATA, `TPGIO_IDX_C_DATA,
                `TPGIO_IDX_A_DIR, `TPGIO_IDX_B_DIR, `TPGIO_IDX_C_DIR,
                `TPGIO_IDX_A_PUE, `TPGIO_IDX_C_PUE,
                `TPGIO_IDX_KBI_EN, `TPGIO_IDX_ADC_SEL: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // write strobe for one register: a completed, mapped write to that index
    function hit;
        input       go;
        input [7:0] i;
        input [7:0] sel;
        begin
            hit = go && (i == sel);
        end
    endfunction

    // top bit of the decoded word flags an address that may be mapped
    assign widx    = word_index(paddr);
    assign idx     = widx[7:0];
    assign addr_ok = widx[8] && mapped(idx);
    // writes land at the edge that ends the access phase, pready high there
    assign wr_acc  = psel & penable & pready & pwrite;
    assign rd_acc  = psel & ~penable & ~pwrite;
    assign wr_go   = wr_acc & addr_ok;

    // per-register strobes keep each register process small
    assign wr_a_data = hit(wr_go, idx, `TPGIO_IDX_A_DATA);
    assign wr_b_data = hit(wr_go, idx, `TPGIO_IDX_B_DATA);
    assign wr_c_data = hit(wr_go, idx, `TPGIO_IDX_C_DATA);
    assign wr_a_dir  = hit(wr_go, idx, `TPGIO_IDX_A_DIR);
    assign wr_b_dir  = hit(wr_go, idx, `TPGIO_IDX_B_DIR);
    assign wr_c_dir  = hit(wr_go, idx, `TPGIO_IDX_C_DIR);
    assign wr_a_pue  = hit(wr_go, idx, `TPGIO_IDX_A_PUE);
    assign wr_c_pue  = hit(wr_go, idx, `TPGIO_IDX_C_PUE);
    assign wr_kbi    = hit(wr_go, idx, `TPGIO_IDX_KBI_EN);
    assign wr_adc    = hit(wr_go, idx, `TPGIO_IDX_ADC_SEL);

    // pin levels cross in through two flops before any logic looks at them
    tpgio_sync u_sync_a (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (port_a_in),
        .sync_out (a_sync)
    );
    tpgio_sync u_sync_b (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (port_b_in),
        .sync_out (b_sync)
    );
    tpgio_sync u_sync_c (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in ({1'b0, port_c_in}),
        .sync_out (c_sync)
    );

    // one-hot analog selection from the channel field when enabled
    always @* begin
        analog_force = 8'h00;
        if (adc_select_q[`TPGIO_ADC_EN_BIT]) begin
            analog_force[adc_select_q[`TPGIO_ADC_CH_MSB:0]] = 1'b1; // [R13]
        end
    end

    tpgio_pin u_pin_a (
        .latch_val    (first_port_latch),
        .dir_val      (first_port_direction_q),
        .pue_val      (first_port_pullup_enable_q),
        .pin_level    (a_sync),
        .analog_force (8'h00),
        .drive_en     (a_drv),
        .pullup_en    (a_pu),
        .read_val     (a_rd)
    );
    // second port has no pullup control: enable tied off [R12]
    tpgio_pin u_pin_b (
        .latch_val    (second_port_latch),
        .dir_val      (second_port_direction_q),
        .pue_val      (8'h00),
        .pin_level    (b_sync),
        .analog_force (analog_force),
        .drive_en     (b_drv),
        .pullup_en    (b_pu),
        .read_val     (b_rd)
    );
    tpgio_pin u_pin_c (
        .latch_val    (third_port_latch),
        .dir_val      (third_port_direction_q),
        .pue_val      (third_port_pullup_enable_q),
        .pin_level    (c_sync),
        .analog_force (8'h00),
        .drive_en     (c_drv),
        .pullup_en    (c_pu),
        .read_val     (c_rd)
    );

    // data latches: written whatever the direction, untouched by reset
    always @(posedge ref_clk) begin
        if (wr_a_data) begin
            first_port_latch <= pwdata[7:0];                       // [R7] [R4]
        end
    end

    // second latch also drives the pins that the analog select leaves digital
    always @(posedge ref_clk) begin
        if (wr_b_data) begin
            second_port_latch <= pwdata[7:0];                      // [R7] [R14]
        end
    end

    // bit 7 kept low so the missing position reads zero
    always @(posedge ref_clk) begin
        if (wr_c_data) begin
            third_port_latch <= pwdata[7:0] & `TPGIO_C_MASK;       // [R15] [R19]
        end
    end

    // first port controls: direction, pullup enables, keypad enables
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_port_direction_q     <= `TPGIO_DIR_RST;          // [R2]
            first_port_pullup_enable_q <= `TPGIO_PUE_RST;
            keypad_irq_enable_bits_q   <= `TPGIO_KBI_RST;
        end else begin
            if (wr_a_dir) begin
                first_port_direction_q <= pwdata[7:0];             // [R1] [R3]
            end
            if (wr_a_pue) begin
                first_port_pullup_enable_q <= pwdata[7:0];         // [R11]
            end
            if (wr_kbi) begin
                keypad_irq_enable_bits_q <= pwdata[7:0];           // [R18]
            end
        end
    end

    // second port controls: direction and analog channel select
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            second_port_direction_q <= `TPGIO_DIR_RST;             // [R2]
            adc_select_q            <= `TPGIO_ADC_RST;
        end else begin
            if (wr_b_dir) begin
                second_port_direction_q <= pwdata[7:0];            // [R3]
            end
            if (wr_adc) begin
                adc_select_q <= pwdata[3:0];                       // [R13]
            end
        end
    end

    // third port controls; only bits 0 to 6 exist
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            third_port_direction_q     <= `TPGIO_DIR_RST;          // [R2]
            third_port_pullup_enable_q <= `TPGIO_PUE_RST;
        end else begin
            if (wr_c_dir) begin
                third_port_direction_q <= pwdata[7:0] & `TPGIO_C_MASK; // [R15] [R19]
            end
            if (wr_c_pue) begin
                third_port_pullup_enable_q <= pwdata[7:0] & `TPGIO_C_MASK; // [R19]
            end
        end
    end

    // read mux: data locations return the latch or the pin per bit
    always @* begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (rd_acc || (psel && !penable)) begin
            pslverr_d = ~addr_ok;
            case (idx)
                `TPGIO_IDX_A_DATA:  prdata_d[7:0] = a_rd;          // [R5] [R6]
                `TPGIO_IDX_B_DATA:  prdata_d[7:0] = b_rd;          // [R5] [R6]
                `TPGIO_IDX_C_DATA:  prdata_d[7:0] = c_rd & `TPGIO_C_MASK; // [R19]
                `TPGIO_IDX_A_DIR:   prdata_d[7:0] = first_port_direction_q;  // [R3]
                `TPGIO_IDX_B_DIR:   prdata_d[7:0] = second_port_direction_q; // [R3]
                `TPGIO_IDX_C_DIR:   prdata_d[7:0] = third_port_direction_q;  // [R3]
                `TPGIO_IDX_A_PUE:   prdata_d[7:0] = first_port_pullup_enable_q;
                `TPGIO_IDX_C_PUE:   prdata_d[7:0] = third_port_pullup_enable_q;
                `TPGIO_IDX_KBI_EN:  prdata_d[7:0] = keypad_irq_enable_bits_q;
                `TPGIO_IDX_ADC_SEL: prdata_d[3:0] = adc_select_q;
                default:            prdata_d      = 32'h0000_0000;
            endcase
            // refused accesses return zero data, whatever the low index bits hit
            if (!addr_ok) begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    // bus answer registered: read data captured in setup, shown in access
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                prdata  <= pwrite ? 32'h0000_0000 : prdata_d;
                pslverr <= pslverr_d;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // pad controls registered so every output comes from a flop
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_oe     <= 8'h00;
            port_a_pullup <= 8'h00;
            port_b_oe     <= 8'h00;
            port_c_oe     <= 7'h00;
            port_c_pullup <= 7'h00;
        end else begin
            port_a_oe     <= a_drv;                                // [R1]
            port_a_pullup <= a_pu;                                 // [R9] [R10]
            port_b_oe     <= b_drv;                                // [R1] [R14]
            port_c_oe     <= c_drv[6:0];                           // [R15]
            port_c_pullup <= c_pu[6:0];                            // [R9] [R10]
        end
    end

    // drive values copy the latches and, like them, ignore reset
    always @(posedge ref_clk) begin
        port_a_out <= first_port_latch;                            // [R4]
        port_b_out <= second_port_latch;                           // [R4]
        port_c_out <= third_port_latch[6:0];                       // [R4]
    end

    // side functions: analog select and keypad view of the first port
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            analog_channel_pins <= 8'h00;
            keypad_input_pins   <= 8'h00;
        end else begin
            analog_channel_pins <= analog_force;                   // [R13]
            // keypad sees the synchronised pin only where enabled
            keypad_input_pins   <= a_sync & keypad_irq_enable_bits_q; // [R18]
        end
    end
endmodule
